/* hdl/md_pkg.sv */
/*
  Shared constants and types of the moisture detection control and result block:
  register indices, field positions, reset values, result codes and check timing.
  Assumes a 50 MHz reference clock and a 32-bit register bus, one register per word.
*/
package md_pkg;
  localparam int MD_ADDR_W = 10;
  // register indices; byte address is four times the index
  localparam logic [7:0] MD_IDX_RETRY = 8'h70;
  localparam logic [7:0] MD_IDX_AVGNUM = 8'h72;
  localparam logic [7:0] MD_IDX_TARGET = 8'h74;
  localparam logic [7:0] MD_IDX_THRESH = 8'h75;
  localparam logic [7:0] MD_IDX_CTL = 8'h76;
  localparam logic [7:0] MD_IDX_CUR = 8'h77;
  localparam logic [7:0] MD_IDX_AVG = 8'h78;
  localparam logic [7:0] MD_IDX_PEAK = 8'h79;
  localparam logic [7:0] MD_IDX_FLOOR = 8'h7A;
  localparam logic [7:0] MD_IDX_STATE = 8'h7B;
  localparam logic [7:0] MD_IDX_IRQ_ST = 8'h7C;
  localparam logic [7:0] MD_IDX_IRQ_MASK = 8'h7D;
  // control register bit positions
  localparam int MD_CTL_AUTO = 6;
  localparam int MD_CTL_MAN = 4;
  localparam int MD_CTL_RTY = 2;
  localparam int MD_CTL_REARM = 0;
  // state register and interrupt bit positions
  localparam int MD_ST_WET = 0;
  localparam int MD_ST_BUSY = 1;
  localparam int MD_IRQ_DONE = 0;
  localparam int MD_IRQ_WET = 1;
  localparam int MD_IRQ_DRY = 2;
  localparam int MD_IRQ_W = 3;
  // reset values
  localparam logic MD_AUTO_RST = 1'b1;
  localparam logic MD_REARM_RST = 1'b1;
  localparam logic [7:0] MD_THRESH_RST = 8'h77;
  localparam logic [2:0] MD_RETRY_RST = 3'h1;
  localparam logic [2:0] MD_AVGNUM_RST = 3'h0;
  localparam logic [1:0] MD_TARGET_RST = 2'h0;
  localparam logic [MD_IRQ_W-1:0] MD_MASK_RST = 3'h0;
  // pullup current codes: 0 1uA, 1 4uA, 2 16uA, 3 64uA
  localparam logic [1:0] MD_CUR_1UA = 2'h0;
  localparam logic [1:0] MD_CUR_64UA = 2'h3;
  localparam logic [7:0] MD_READ_ZERO = 8'h00;
  localparam logic [7:0] MD_READ_FULL = 8'hFF;
  // weight of one reading count, for software scaling
  localparam real MD_LSB_MV = 5.882;
  localparam real MD_LSB_PCT = 0.392;
  // automatic check period
  localparam int unsigned MD_CHECK_S = 16;
  localparam int unsigned MD_CLK_HZ = 50_000_000;
  localparam int unsigned MD_CHECK_CYCLES = MD_CHECK_S * MD_CLK_HZ;

  typedef enum logic [2:0] {
    MD_RES_DRY = 3'h0,
    MD_RES_OPEN = 3'h1,
    MD_RES_GROUND = 3'h2,
    MD_RES_SHORT = 3'h3,
    MD_RES_ABORT = 3'h4
  } md_result_e;

  typedef enum logic [1:0] {
    MD_SRC_NONE = 2'h0,
    MD_SRC_AUTO = 2'h1,
    MD_SRC_MAN = 2'h2,
    MD_SRC_RTY = 2'h3
  } md_src_e;

  typedef enum logic [2:0] {
    MD_SQ_IDLE = 3'b001,
    MD_SQ_ACC = 3'b010,
    MD_SQ_EVAL = 3'b100
  } md_seq_st_e;
endpackage

/* hdl/md_seq.sv */
/*
  Measurement sequencer: gathers 2^n ADC samples at one pullup current,
  retries clamped measurements and classifies the outcome.
  Assumes the on-chip ADC runs on ref_clk, so its samples need no synchroniser.
*/
`timescale 1ns/100ps
module md_seq
  import md_pkg::*;
(
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic start,
  input wire logic [1:0] target_cur,
  input wire logic [2:0] avg_sel,
  input wire logic [2:0] retry_max,
  input wire logic [7:0] wet_thresh,
  input wire logic adc_valid,
  input wire logic [7:0] adc_data,
  output logic afe_enable,
  output logic [1:0] afe_current,
  output logic busy,
  output logic done,
  output md_result_e result,
  output logic [7:0] res_avg,
  output logic [7:0] res_peak,
  output logic [7:0] res_floor
);
  md_seq_st_e state;
  logic [2:0] sel_l;
  logic [2:0] tries;
  logic [2:0] tries_max;
  logic [7:0] thr_l;
  logic [7:0] cnt;
  logic [7:0] peak;
  logic [7:0] floor_v;
  logic [14:0] sum;
  logic [7:0] avg;
  logic clamp;
  logic retry_go;
  logic last;

  function automatic md_result_e classify(input logic cl, input logic lowcur,
                                          input logic [7:0] fl, input logic [7:0] a,
                                          input logic [7:0] thr);
    if (cl && !lowcur) classify = MD_RES_ABORT;
    else if (cl) classify = MD_RES_OPEN;
    else if (fl == MD_READ_ZERO) classify = MD_RES_GROUND;
    else if (a < thr) classify = MD_RES_SHORT;
    else classify = MD_RES_DRY;
  endfunction

  // sum never exceeds 255 << sel, so the shifted value fits eight bits
  assign avg = 8'(sum >> sel_l);
  assign clamp = peak == MD_READ_FULL;
  assign last = cnt == 8'((9'h001 << sel_l) - 9'h001);
  assign retry_go = state == MD_SQ_EVAL && clamp && afe_current != MD_CUR_1UA &&
                    tries < tries_max;
  assign afe_enable = state == MD_SQ_ACC;
  assign busy = state != MD_SQ_IDLE;

  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      state <= MD_SQ_IDLE;
    end else begin
      unique case (state)
        MD_SQ_IDLE: if (start) state <= MD_SQ_ACC;
        MD_SQ_ACC: if (adc_valid && last) state <= MD_SQ_EVAL;
        MD_SQ_EVAL: state <= retry_go ? MD_SQ_ACC : MD_SQ_IDLE;
      endcase
    end
  end

  // settings are frozen at start so a register write cannot skew a run
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      sel_l <= MD_AVGNUM_RST;
      thr_l <= MD_THRESH_RST;
      afe_current <= MD_TARGET_RST;
      tries_max <= MD_RETRY_RST;
      tries <= 3'h0;
    end else if (state == MD_SQ_IDLE && start) begin
      sel_l <= avg_sel;
      thr_l <= wet_thresh;
      afe_current <= target_cur;
      tries_max <= retry_max;
      tries <= 3'h0;
    end else if (retry_go) begin
      tries <= tries + 3'h1;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!nrst || (state == MD_SQ_IDLE && start) || retry_go) begin
      cnt <= 8'h00;
      sum <= 15'h0000;
      peak <= MD_READ_ZERO;
      floor_v <= MD_READ_FULL;
    end else if (state == MD_SQ_ACC && adc_valid) begin
      cnt <= cnt + 8'h01;
      sum <= sum + {7'h00, adc_data};
      if (adc_data > peak) peak <= adc_data;
      if (adc_data < floor_v) floor_v <= adc_data;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      done <= 1'b0;
      result <= MD_RES_DRY;
      res_avg <= MD_READ_ZERO;
      res_peak <= MD_READ_ZERO;
      res_floor <= MD_READ_ZERO;
    end else begin
      done <= state == MD_SQ_EVAL && !retry_go;
      if (state == MD_SQ_EVAL && !retry_go) begin
        result <= classify(clamp, afe_current == MD_CUR_1UA, floor_v, avg, thr_l);
        res_avg <= avg;
        res_peak <= peak;
        res_floor <= floor_v;
      end
    end
  end

  default clocking sq_cb @(posedge ref_clk); endclocking
  default disable iff (!nrst);

  property p_abort_after_retries;
    state == MD_SQ_EVAL && clamp && afe_current != MD_CUR_1UA && tries == tries_max
      |=> done && result == MD_RES_ABORT;
  endproperty
  a_abort_after_retries: assert property (p_abort_after_retries)
    else $error("clamped run did not abort after last retry");

  property p_short_below_thr;
    state == MD_SQ_EVAL && !clamp && floor_v != MD_READ_ZERO && avg < thr_l
      |=> done && result == MD_RES_SHORT;
  endproperty
  a_short_below_thr: assert property (p_short_below_thr)
    else $error("reading under threshold not reported as short");

  property p_sample_count;
    state == MD_SQ_ACC && adc_valid && cnt == 8'((9'h001 << sel_l) - 9'h001)
      |=> state == MD_SQ_EVAL;
  endproperty
  a_sample_count: assert property (p_sample_count)
    else $error("averaging did not end after 2^n samples");
endmodule

/* hdl/md_top.sv */
/*
  Moisture detection control and result registers with their sequencer,
  an automatic 16 s check timer and an interrupt, behind an Avalon-MM slave.
  Assumes a single 50 MHz clock, a synchronous active-low reset and an
  on-chip ADC and analog front end running on the same clock.
*/
// Decided for this implementation: the Avalon-MM interface to the registers.
// What this block does
// - With automatic enable set, check moisture every 16 s, first 16 s after reset.
// - Writing one to the manual request bit starts one detection as soon as the sequencer is free.
// - Manual request reads one while running and self-clears when detection ends.
// - Retry write starts a new check only when moisture was found; else ignored.
// - Retry bit reads one while the retry runs and self-clears when done.
// - With re-arm set, host detection re-arms itself once moisture is gone.
// - A read-only 2-bit field reports the final pullup current code.
// - Final current reads zero on Abort or Open and three on Short.
// - Average reading register: zero on Abort or Ground, all ones on Open.
// - Peak reading register: zero on Abort or Ground, all ones on Open.
// - Floor reading register: zero on Abort or Ground, all ones on Open.
// - One reading count stands for 5.882 mV, about 0.392 percent.
// - Measurements compare against an 8-bit threshold, reset 0x77.
// - A 2-bit target current sets the moisture resistance threshold, reset zero.
// - A 3-bit count repeats clamped measurements; exhausted retries report Abort.
// - A 3-bit field averages two to that power ADC samples per measurement.
`timescale 1ns/100ps
module md_top
  import md_pkg::*;
#(
  parameter int unsigned CHECK_CYCLES = MD_CHECK_CYCLES
) (
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic [MD_ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [3:0] avs_byteenable,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic adc_valid,
  input wire logic [7:0] adc_data,
  output logic afe_enable,
  output logic [1:0] afe_current,
  output logic host_detect_armed,
  output logic host_rearm,
  output logic irq
);
  logic ack;
  logic [7:0] idx;
  logic wr_en;
  logic [7:0] wd;
  logic [31:0] next_readdata;

  logic auto_en;
  logic rearm_en;
  logic man_req;
  logic rty_req;
  logic [2:0] retry_max;
  logic [2:0] avg_sel;
  logic [1:0] target_cur;
  logic [7:0] wet_thresh;

  logic [1:0] final_current_code;
  logic [7:0] final_avg_reading;
  logic [7:0] final_peak_reading;
  logic [7:0] final_floor_reading;
  logic wet;
  logic [MD_IRQ_W-1:0] irq_st;
  logic [MD_IRQ_W-1:0] irq_mask;
  logic [MD_IRQ_W-1:0] irq_ev;
  logic [MD_IRQ_W-1:0] irq_clr;

  logic [31:0] tmr;
  logic tick;
  logic auto_pend;
  md_src_e run_src;
  md_src_e launch_src;
  logic ctl_wr;
  logic man_set;
  logic rty_set;
  logic dry_rearm;

  logic seq_start;
  logic seq_busy;
  logic seq_done;
  md_result_e seq_result;
  logic [7:0] seq_avg;
  logic [7:0] seq_peak;
  logic [7:0] seq_floor;

  function automatic logic reg_hit(input logic en, input logic [7:0] at,
                                   input logic [7:0] want);
    reg_hit = en && at == want;
  endfunction

  function automatic logic [7:0] force_reading(input md_result_e r, input logic [7:0] raw);
    if (r == MD_RES_ABORT || r == MD_RES_GROUND) force_reading = MD_READ_ZERO;
    else if (r == MD_RES_OPEN) force_reading = MD_READ_FULL;
    else force_reading = raw;
  endfunction

  // bus slave: one wait cycle, then the write lands and read data stands
  assign idx = avs_address[MD_ADDR_W-1:2];
  assign avs_waitrequest = (avs_read || avs_write) && !ack;
  assign wr_en = avs_write && ack && avs_address[1:0] == 2'h0 && avs_byteenable[0];
  assign wd = avs_writedata[7:0];

  always_ff @(posedge ref_clk) begin
    if (!nrst) ack <= 1'b0;
    else ack <= (avs_read || avs_write) && !ack;
  end

  always_comb begin
    next_readdata = 32'h0000_0000;
    if (avs_address[1:0] == 2'h0) begin
      case (idx)
        MD_IDX_RETRY: next_readdata[2:0] = retry_max;
        MD_IDX_AVGNUM: next_readdata[2:0] = avg_sel;
        MD_IDX_TARGET: next_readdata[1:0] = target_cur;
        MD_IDX_THRESH: next_readdata[7:0] = wet_thresh;
        MD_IDX_CTL: begin
          next_readdata[MD_CTL_AUTO] = auto_en;
          next_readdata[MD_CTL_MAN] = man_req;
          next_readdata[MD_CTL_RTY] = rty_req;
          next_readdata[MD_CTL_REARM] = rearm_en;
        end
        MD_IDX_CUR: next_readdata[1:0] = final_current_code;
        MD_IDX_AVG: next_readdata[7:0] = final_avg_reading;
        MD_IDX_PEAK: next_readdata[7:0] = final_peak_reading;
        MD_IDX_FLOOR: next_readdata[7:0] = final_floor_reading;
        MD_IDX_STATE: begin
          next_readdata[MD_ST_WET] = wet;
          next_readdata[MD_ST_BUSY] = seq_busy;
        end
        MD_IDX_IRQ_ST: next_readdata[MD_IRQ_W-1:0] = irq_st;
        MD_IDX_IRQ_MASK: next_readdata[MD_IRQ_W-1:0] = irq_mask;
        default: next_readdata = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!nrst) avs_readdata <= 32'h0000_0000;
    else if (avs_read && !ack) avs_readdata <= next_readdata;
  end

  // configuration registers
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      retry_max <= MD_RETRY_RST;
      avg_sel <= MD_AVGNUM_RST;
      target_cur <= MD_TARGET_RST;
      wet_thresh <= MD_THRESH_RST;
    end else begin
      if (reg_hit(wr_en, idx, MD_IDX_RETRY)) retry_max <= wd[2:0];
      if (reg_hit(wr_en, idx, MD_IDX_AVGNUM)) avg_sel <= wd[2:0];
      if (reg_hit(wr_en, idx, MD_IDX_TARGET)) target_cur <= wd[1:0];
      if (reg_hit(wr_en, idx, MD_IDX_THRESH)) wet_thresh <= wd;
    end
  end

  assign ctl_wr = reg_hit(wr_en, idx, MD_IDX_CTL);
  assign man_set = ctl_wr && wd[MD_CTL_MAN];
  assign rty_set = ctl_wr && wd[MD_CTL_RTY] && wet;

  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      auto_en <= MD_AUTO_RST;
      rearm_en <= MD_REARM_RST;
    end else if (ctl_wr) begin
      auto_en <= wd[MD_CTL_AUTO];
      rearm_en <= wd[MD_CTL_REARM];
    end
  end

  // a new request in the finishing cycle wins over the self-clear
  always_ff @(posedge ref_clk) begin
    if (!nrst) man_req <= 1'b0;
    else if (man_set) man_req <= 1'b1;
    else if (seq_done && run_src == MD_SRC_MAN) man_req <= 1'b0;
  end

  always_ff @(posedge ref_clk) begin
    if (!nrst) rty_req <= 1'b0;
    else if (rty_set) rty_req <= 1'b1;
    else if (seq_done && run_src == MD_SRC_RTY) rty_req <= 1'b0;
  end

  // free-running period timer; the first tick comes one full period after reset
  assign tick = tmr == CHECK_CYCLES - 32'h0000_0001;

  always_ff @(posedge ref_clk) begin
    if (!nrst || tick) tmr <= 32'h0000_0000;
    else tmr <= tmr + 32'h0000_0001;
  end

  always_ff @(posedge ref_clk) begin
    if (!nrst) auto_pend <= 1'b0;
    else if (tick && auto_en) auto_pend <= 1'b1;
    else if (seq_start && launch_src == MD_SRC_AUTO) auto_pend <= 1'b0;
  end

  // a manual request outranks a retry, which outranks the periodic check
  always_comb begin
    launch_src = MD_SRC_NONE;
    if (run_src == MD_SRC_NONE && !seq_busy) begin
      if (man_req) launch_src = MD_SRC_MAN;
      else if (rty_req) launch_src = MD_SRC_RTY;
      else if (auto_pend) launch_src = MD_SRC_AUTO;
    end
  end

  assign seq_start = launch_src != MD_SRC_NONE;

  always_ff @(posedge ref_clk) begin
    if (!nrst) run_src <= MD_SRC_NONE;
    else if (seq_start) run_src <= launch_src;
    else if (seq_done) run_src <= MD_SRC_NONE;
  end

  md_seq u_seq (
    .ref_clk(ref_clk),
    .nrst(nrst),
    .start(seq_start),
    .target_cur(target_cur),
    .avg_sel(avg_sel),
    .retry_max(retry_max),
    .wet_thresh(wet_thresh),
    .adc_valid(adc_valid),
    .adc_data(adc_data),
    .afe_enable(afe_enable),
    .afe_current(afe_current),
    .busy(seq_busy),
    .done(seq_done),
    .result(seq_result),
    .res_avg(seq_avg),
    .res_peak(seq_peak),
    .res_floor(seq_floor)
  );

  // results are captured once per finished measurement, with outcome overrides
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      final_current_code <= MD_CUR_1UA;
      final_avg_reading <= MD_READ_ZERO;
      final_peak_reading <= MD_READ_ZERO;
      final_floor_reading <= MD_READ_ZERO;
    end else if (seq_done) begin
      if (seq_result == MD_RES_ABORT || seq_result == MD_RES_OPEN)
        final_current_code <= MD_CUR_1UA;
      else if (seq_result == MD_RES_SHORT)
        final_current_code <= MD_CUR_64UA;
      else
        final_current_code <= afe_current;
      final_avg_reading <= force_reading(seq_result, seq_avg);
      final_peak_reading <= force_reading(seq_result, seq_peak);
      final_floor_reading <= force_reading(seq_result, seq_floor);
    end
  end

  // host detection stays blocked while wet; a dry result re-arms it when
  // auto re-arm is on, or when software asked for the retry
  assign dry_rearm = seq_done && seq_result == MD_RES_DRY && wet &&
                     (rearm_en || run_src == MD_SRC_RTY);

  always_ff @(posedge ref_clk) begin
    if (!nrst) wet <= 1'b0;
    else if (seq_done && seq_result == MD_RES_SHORT) wet <= 1'b1;
    else if (dry_rearm) wet <= 1'b0;
  end

  always_ff @(posedge ref_clk) begin
    if (!nrst) host_rearm <= 1'b0;
    else host_rearm <= dry_rearm;
  end

  assign host_detect_armed = !wet;

  // interrupts: sticky, write one to clear, a new event wins over the clear
  assign irq_ev[MD_IRQ_DONE] = seq_done;
  assign irq_ev[MD_IRQ_WET] = seq_done && seq_result == MD_RES_SHORT && !wet;
  assign irq_ev[MD_IRQ_DRY] = dry_rearm;
  assign irq_clr = reg_hit(wr_en, idx, MD_IDX_IRQ_ST) ? wd[MD_IRQ_W-1:0] : 3'h0;

  always_ff @(posedge ref_clk) begin
    if (!nrst) irq_st <= 3'h0;
    else irq_st <= (irq_st & ~irq_clr) | irq_ev;
  end

  always_ff @(posedge ref_clk) begin
    if (!nrst) irq_mask <= MD_MASK_RST;
    else if (reg_hit(wr_en, idx, MD_IDX_IRQ_MASK)) irq_mask <= wd[MD_IRQ_W-1:0];
  end

  assign irq = |(irq_st & irq_mask);

  default clocking md_cb @(posedge ref_clk); endclocking
  default disable iff (!nrst);

  property p_auto_tick;
    tick && auto_en |=> auto_pend || run_src == MD_SRC_AUTO;
  endproperty
  a_auto_tick: assert property (p_auto_tick)
    else $error("periodic tick did not queue a check");

  property p_man_launch;
    man_set && run_src == MD_SRC_NONE && !seq_busy |-> ##2 seq_busy;
  endproperty
  a_man_launch: assert property (p_man_launch)
    else $error("manual request did not start detection");

  property p_man_clear;
    seq_done && run_src == MD_SRC_MAN && !man_set |=> !man_req;
  endproperty
  a_man_clear: assert property (p_man_clear)
    else $error("manual request bit not cleared at end");

  property p_man_running;
    run_src == MD_SRC_MAN && !seq_done |-> man_req;
  endproperty
  a_man_running: assert property (p_man_running)
    else $error("manual request bit low during its run");

  property p_rty_ignored;
    ctl_wr && wd[MD_CTL_RTY] && !wet && !rty_req |=> !rty_req [*2];
  endproperty
  a_rty_ignored: assert property (p_rty_ignored)
    else $error("retry accepted without moisture");

  property p_rty_clear;
    seq_done && run_src == MD_SRC_RTY && !rty_set |=> !rty_req;
  endproperty
  a_rty_clear: assert property (p_rty_clear)
    else $error("retry bit not cleared after retry");

  property p_rearm;
    seq_done && seq_result == MD_RES_DRY && wet && rearm_en |=> !wet && host_rearm;
  endproperty
  a_rearm: assert property (p_rearm)
    else $error("dry result did not re-arm host detection");

  property p_cur_dry;
    seq_done && seq_result == MD_RES_DRY |=> final_current_code == $past(afe_current);
  endproperty
  a_cur_dry: assert property (p_cur_dry)
    else $error("final current differs from current used");

  property p_cur_force;
    seq_done && seq_result inside {MD_RES_ABORT, MD_RES_OPEN, MD_RES_SHORT}
      |=> final_current_code == (($past(seq_result) == MD_RES_SHORT) ?
                                  MD_CUR_64UA : MD_CUR_1UA);
  endproperty
  a_cur_force: assert property (p_cur_force)
    else $error("final current not forced for outcome");

  property p_avg_open;
    seq_done && seq_result == MD_RES_OPEN |=> final_avg_reading == MD_READ_FULL;
  endproperty
  a_avg_open: assert property (p_avg_open)
    else $error("average not all ones on open");

  property p_peak_ground;
    seq_done && seq_result == MD_RES_GROUND |=> final_peak_reading == MD_READ_ZERO;
  endproperty
  a_peak_ground: assert property (p_peak_ground)
    else $error("peak not zero on ground");

  property p_floor_abort;
    seq_done && seq_result == MD_RES_ABORT |=> final_floor_reading == MD_READ_ZERO;
  endproperty
  a_floor_abort: assert property (p_floor_abort)
    else $error("floor not zero on abort");

  property p_zero_write;
    ctl_wr && !wd[MD_CTL_MAN] && man_req && !seq_done |=> man_req;
  endproperty
  a_zero_write: assert property (p_zero_write)
    else $error("writing zero dropped a manual request");
endmodule

/* sim/md_top_tb.sv */
/*
  Self-checking bench for md_top: register resets, manual runs, retry, re-arm,
  forced outcomes, automatic checks and the interrupt.
  Assumes md_pkg and md_top are compiled first; one 50 MHz clock.
*/
`timescale 1ns/100ps
module md_top_tb;
  import md_pkg::*;
  localparam int unsigned CYC = 200;
  logic ref_clk = 1'b0;
  logic nrst = 1'b0;
  logic [MD_ADDR_W-1:0] avs_address = '0;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [3:0] avs_byteenable = 4'hF;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata;
  logic avs_waitrequest, afe_enable, host_detect_armed, host_rearm, irq, afe_q;
  logic adc_valid = 1'b0;
  logic [7:0] adc_data = 8'h00;
  logic [1:0] afe_current;
  logic [7:0] q;
  int error_cnt = 0;
  int checks = 0;
  int rearm_cnt = 0;
  int rises = 0;

  md_top #(.CHECK_CYCLES(CYC)) md_top_inst (.ref_clk(ref_clk), .nrst(nrst),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_byteenable(avs_byteenable), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .adc_valid(adc_valid),
    .adc_data(adc_data), .afe_enable(afe_enable), .afe_current(afe_current),
    .host_detect_armed(host_detect_armed), .host_rearm(host_rearm), .irq(irq));

  initial forever #10 ref_clk = ~ref_clk;
  always @(posedge ref_clk) begin
    afe_q <= afe_enable;
    if (host_rearm === 1'b1) rearm_cnt <= rearm_cnt + 1;
    if (afe_enable === 1'b1 && afe_q !== 1'b1) rises <= rises + 1;
  end

  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic complete_run();
    $display("checks %0d mismatches %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  // request held until waitrequest is sampled low, then released
  task automatic bus(input logic rd, input logic [7:0] idx, input logic [7:0] d);
    @(posedge ref_clk);
    avs_read <= rd;
    avs_write <= !rd;
    avs_address <= {idx, 2'b00};
    avs_writedata <= {24'h0, d};
    @(posedge ref_clk);
    // no local limit: only the watchdog may end a wait for the answer
    while (avs_waitrequest !== 1'b0) begin
      @(posedge ref_clk);
    end
    q = avs_readdata[7:0];
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] idx, input logic [7:0] d); bus(1'b0, idx, d); endtask
  task automatic rd(input logic [7:0] idx); bus(1'b1, idx, 8'h00); endtask

  // two idle edges first so a stale afe_enable from the last round is not trusted
  task automatic smp(input logic [7:0] v);
    @(posedge ref_clk);
    @(posedge ref_clk);
    while (afe_enable !== 1'b1) begin
      @(posedge ref_clk);
    end
    adc_valid <= 1'b1;
    adc_data <= v;
    @(posedge ref_clk);
    adc_valid <= 1'b0;
    adc_data <= ~v;
  endtask

  task automatic wait_idle();
    rd(MD_IDX_STATE);
    while (q[MD_ST_BUSY] !== 1'b0) begin
      rd(MD_IDX_STATE);
    end
  endtask

  task automatic run(input logic [7:0] c, input logic [7:0] a, input logic [7:0] b, input int n);
    wr(MD_IDX_CTL, c);
    rd(MD_IDX_CTL);
    check("request bit running", q & 8'h14, c & 8'h14);
    for (int i = 0; i < n; i++) smp(i == 0 ? a : b);
    wait_idle();
    rd(MD_IDX_CTL);
    check("request bit cleared", q & 8'h14, 8'h00);
  endtask

  task automatic res(input logic [1:0] c, input logic [7:0] a, input logic [7:0] p,
                     input logic [7:0] f);
    rd(MD_IDX_CUR);
    check("final current", q, {6'h0, c});
    rd(MD_IDX_AVG);
    check("final average", q, a);
    rd(MD_IDX_PEAK);
    check("final peak", q, p);
    rd(MD_IDX_FLOOR);
    check("final floor", q, f);
  endtask

  task automatic t_reset();
    rd(MD_IDX_CTL);
    check("control reset", q, 8'h41);
    wr(MD_IDX_CTL, 8'h00);
    rd(MD_IDX_THRESH);
    check("threshold reset", q, 8'h77);
    rd(MD_IDX_TARGET);
    check("target reset", q, 8'h00);
    rd(MD_IDX_RETRY);
    check("retry reset", q, 8'h01);
    res(2'h0, 8'h00, 8'h00, 8'h00);
    avs_byteenable <= 4'h0;
    wr(MD_IDX_THRESH, 8'h12);
    avs_byteenable <= 4'hF;
    rd(MD_IDX_THRESH);
    check("lane-less write", q, 8'h77);
    rd(8'h7F);
    check("unmapped read", q, 8'h00);
    $display("test reset done");
  endtask

  task automatic t_dry();
    wr(MD_IDX_IRQ_MASK, 8'h01);
    wr(MD_IDX_TARGET, 8'h02);
    wr(MD_IDX_CTL, 8'h04);
    rd(MD_IDX_CTL);
    check("retry while dry", q, 8'h00);
    run(8'h10, 8'h80, 8'h80, 1);
    res(2'h2, 8'h80, 8'h80, 8'h80);
    check("applied current", {6'h0, afe_current}, 8'h02);
    check("irq raised", {7'h0, irq}, 8'h01);
    wr(MD_IDX_IRQ_ST, 8'h07);
    @(posedge ref_clk);
    check("irq cleared", {7'h0, irq}, 8'h00);
    $display("test dry done");
  endtask

  task automatic t_wet();
    int rc;
    wr(MD_IDX_AVGNUM, 8'h01);
    run(8'h10, 8'h10, 8'h20, 2);
    res(2'h3, 8'h18, 8'h20, 8'h10);
    check("armed while wet", {7'h0, host_detect_armed}, 8'h00);
    run(8'h10, 8'h80, 8'h80, 2);
    rd(MD_IDX_STATE);
    check("wet kept without re-arm", q & 8'h01, 8'h01);
    run(8'h04, 8'h80, 8'h80, 2);
    rd(MD_IDX_STATE);
    check("wet cleared by retry", q & 8'h01, 8'h00);
    run(8'h10, 8'h10, 8'h20, 2);
    rc = rearm_cnt;
    run(8'h11, 8'h80, 8'h80, 2);
    check("re-armed", {7'h0, host_detect_armed}, 8'h01);
    check("re-arm pulses", 8'(rearm_cnt - rc), 8'h01);
    $display("test wet done");
  endtask

  task automatic t_force();
    int r0;
    wr(MD_IDX_AVGNUM, 8'h00);
    wr(MD_IDX_TARGET, 8'h00);
    run(8'h10, 8'hFF, 8'hFF, 1);
    res(2'h0, 8'hFF, 8'hFF, 8'hFF);
    wr(MD_IDX_TARGET, 8'h01);
    run(8'h10, 8'h00, 8'h00, 1);
    res(2'h1, 8'h00, 8'h00, 8'h00);
    r0 = rises;
    run(8'h10, 8'hFF, 8'hFF, 2);
    res(2'h0, 8'h00, 8'h00, 8'h00);
    check("abort rounds", 8'(rises - r0), 8'h02);
    $display("test forced outcomes done");
  endtask

  task automatic t_auto();
    int g;
    g = 0;
    wr(MD_IDX_CTL, 8'h40);
    while (afe_enable !== 1'b1 && g < CYC + 10) begin
      @(posedge ref_clk);
      g++;
    end
    check("automatic start", {7'h0, afe_enable}, 8'h01);
    smp(8'h80);
    wait_idle();
    // a zero written mid-run must leave the running manual request alone
    wr(MD_IDX_CTL, 8'h10);
    wr(MD_IDX_CTL, 8'h00);
    rd(MD_IDX_CTL);
    check("zero write kept", q, 8'h10);
    smp(8'h80);
    wait_idle();
    rd(MD_IDX_CTL);
    check("request after zero write", q, 8'h00);
    $display("test auto done");
  endtask

  initial begin
    repeat (3) @(posedge ref_clk);
    nrst <= 1'b1;
    t_reset();
    t_dry();
    t_wet();
    t_force();
    t_auto();
    complete_run();
  end

  // whole sequence needs a few hundred cycles; this bound only catches a hang
  initial begin
    repeat (30000) @(posedge ref_clk);
    error_cnt++;
    $display("[ERR] watchdog expired");
    complete_run();
  end
endmodule
